// ==== rtl/err_severity_mgr.sv ====
// error severity manager: classifies errors, stops or continues, cancels and logs
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module err_severity_mgr #(
	parameter int unsigned N_SRC = err_sev_pkg::NUM_SRC,
	parameter int unsigned N_IFM = err_sev_pkg::NUM_IFM
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire err_sev_pkg::apb_req_t apb_req,
	output err_sev_pkg::apb_rsp_t apb_rsp,
	input wire logic [N_SRC-1:0] err_evt,
	input wire logic [N_IFM-1:0] ifm_err_evt,
	input wire logic [N_SRC-1:0] hw_fault,
	input wire logic [7:0] special_relay_bits_in,
	input wire logic [15:0] special_register_words_in,
	output logic [7:0] special_relay_bits,
	output logic [15:0] special_register_words,
	output logic run_enable,
	output logic outputs_hold,
	output logic outputs_off,
	output logic err_led,
	output logic alarm_led,
	output logic run_led,
	output logic irq
);
	import err_sev_pkg::*;

	// the error code packs eight sources and eight modules into one word
	if (N_SRC < 1 || N_SRC > 8) begin : g_bad_src
		$error("N_SRC must be 1..8");
	end
	if (N_IFM < 1 || N_IFM > 8) begin : g_bad_ifm
		$error("N_IFM must be 1..8");
	end

	// ---- pin synchronisers
	logic [N_SRC-1:0] evt_s1_q, evt_s2_q, evt_s3_q;
	logic [N_IFM-1:0] ifm_s1_q, ifm_s2_q, ifm_s3_q;
	logic [N_SRC-1:0] hw_s1_q, hw_s2_q;
	logic [7:0] rin_s1_q, rin_s2_q;
	logic [15:0] win_s1_q, win_s2_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_s1_q <= '0;
			evt_s2_q <= '0;
			evt_s3_q <= '0;
			ifm_s1_q <= '0;
			ifm_s2_q <= '0;
			ifm_s3_q <= '0;
			hw_s1_q <= '0;
			hw_s2_q <= '0;
			rin_s1_q <= RST_RELAY;
			rin_s2_q <= RST_RELAY;
			win_s1_q <= RST_WORD;
			win_s2_q <= RST_WORD;
		end else begin
			evt_s1_q <= err_evt;
			evt_s2_q <= evt_s1_q;
			evt_s3_q <= evt_s2_q;
			ifm_s1_q <= ifm_err_evt;
			ifm_s2_q <= ifm_s1_q;
			ifm_s3_q <= ifm_s2_q;
			hw_s1_q <= hw_fault;
			hw_s2_q <= hw_s1_q;
			rin_s1_q <= special_relay_bits_in;
			rin_s2_q <= rin_s1_q;
			win_s1_q <= special_register_words_in;
			win_s2_q <= win_s1_q;
		end
	end
	wire [N_SRC-1:0] evt_rise = evt_s2_q & ~evt_s3_q;
	wire [N_IFM-1:0] ifm_rise = ifm_s2_q & ~ifm_s3_q;

	// ---- registers
	logic [4:0] ctrl_q;
	logic [31:0] src_sev_q;
	logic [31:0] ifm_cfg_q;
	logic [IRQ_W-1:0] int_stat_q, int_mask_q;
	logic [7:0] relay_save_q;
	logic [15:0] word_save_q;
	logic [15:0] hist_cnt_q;
	logic [15:0] err_code_q;
	logic [N_SRC-1:0] pend_q;
	logic [N_IFM-1:0] ifm_pend_q;
	logic [N_SRC-1:0] logged_q;
	logic [N_IFM-1:0] ifm_logged_q;
	op_state_t state_q, state_d;
	apb_rsp_t rsp_q;

	function automatic sev_t sev_of(input logic [1:0] code);
		sev_of = sev_t'(code);
	endfunction : sev_of

	// per-source severity; a source flagged as hardware fault is always major
	logic [N_SRC-1:0] src_major, src_mod, src_minor;
	logic [N_IFM-1:0] ifm_major, ifm_mod, ifm_minor;
	genvar gi;
	generate
		for (gi = 0; gi < N_SRC; gi++) begin : g_src
			wire sev_t s = sev_of(src_sev_q[2*gi +: 2]);
			assign src_major[gi] = pend_q[gi] & (hw_s2_q[gi] | s == SEV_MAJOR);
			assign src_mod[gi] = pend_q[gi] & ~hw_s2_q[gi] & (s == SEV_MODERATE);
			assign src_minor[gi] = pend_q[gi] & ~hw_s2_q[gi] & (s == SEV_MINOR | s == SEV_NONE);
		end
		for (gi = 0; gi < N_IFM; gi++) begin : g_ifm
			// per-module reaction setting: 00 ignore as minor, others as coded
			wire sev_t r = sev_of(ifm_cfg_q[2*gi +: 2]);
			assign ifm_major[gi] = ifm_pend_q[gi] & (r == SEV_MAJOR);
			assign ifm_mod[gi] = ifm_pend_q[gi] & (r == SEV_MODERATE);
			assign ifm_minor[gi] = ifm_pend_q[gi] & (r == SEV_MINOR | r == SEV_NONE);
		end
	endgenerate
	wire any_major = |src_major | |ifm_major;
	wire any_mod = |src_mod | |ifm_mod;
	wire any_minor = |src_minor | |ifm_minor;
	wire any_stop = any_major | any_mod;
	wire sev_t top_sev = any_major ? SEV_MAJOR : any_mod ? SEV_MODERATE : any_minor ? SEV_MINOR : SEV_NONE;
	wire [N_SRC-1:0] cont_mask = src_minor;
	wire [N_IFM-1:0] ifm_cont_mask = ifm_minor;

	// ---- cancel: relay on then off, or tool command
	logic relay_fire;
	err_clear_edge u_clr (
		.pclk(pclk),
		.presetn(presetn),
		.relay_in(ctrl_q[CTRL_CLR_RELAY_BIT]),
		.armed(),
		.fire(relay_fire)
	);

	// ---- apb decode
	wire acc = apb_req.psel & apb_req.penable;
	wire wr = acc & apb_req.pwrite;
	wire [11:0] a = apb_req.paddr;
	wire hit_ctrl = a == OFF_CTRL;
	wire hit_stat = a == OFF_INT_STAT;
	wire hit_mask = a == OFF_INT_MASK;
	wire hit_sev = a == OFF_SRC_SEV;
	wire hit_ifm = a == OFF_IFM_CFG;
	wire hit_hist = a == OFF_HIST;
	wire mapped = hit_ctrl | hit_stat | hit_mask | hit_sev | hit_ifm | hit_hist | a == OFF_STATE
		| a == OFF_RELAY_VAL | a == OFF_WORD_VAL | a == OFF_PENDING | a == OFF_ERR_CODE;
	wire tool_clr = wr & hit_ctrl & apb_req.pwdata[CTRL_TOOL_CLR_BIT];
	wire do_cancel = relay_fire | tool_clr;
	wire restart = wr & hit_ctrl & apb_req.pwdata[CTRL_RESTART_BIT];

	// new detection: not already pending; a cancelled source re-logs
	wire [N_SRC-1:0] new_src = evt_rise & ~logged_q;
	wire [N_IFM-1:0] new_ifm = ifm_rise & ~ifm_logged_q;
	wire first_err = (pend_q == '0) & (ifm_pend_q == '0) & ((evt_rise != '0) | (ifm_rise != '0));

	// ---- operating state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			RUN_ST: begin
				if (any_major) state_d = HALT_ST;
				else if (any_mod) state_d = STOP_ST;
				else if (!ctrl_q[CTRL_RUN_BIT]) state_d = STOP_ST;
			end
			STOP_ST: begin
				if (any_major) state_d = HALT_ST;
				else if (!any_stop && restart) state_d = RUN_ST;
			end
			HALT_ST: begin
				if (!any_stop && restart) state_d = RUN_ST;
			end
			default: state_d = HALT_ST;
		endcase
	end

	wire [IRQ_W-1:0] irq_evt = {(new_src != '0) | (new_ifm != '0), do_cancel,
		any_minor, any_mod, any_major};
	logic [31:0] rdata;
	always_comb begin
		rdata = 32'h0000_0000;
		if (hit_ctrl) rdata = {27'h0, ctrl_q};
		if (a == OFF_STATE) rdata = {28'h0, top_sev, state_q};
		if (hit_stat) rdata = {27'h0, int_stat_q};
		if (hit_mask) rdata = {27'h0, int_mask_q};
		if (hit_sev) rdata = src_sev_q;
		if (hit_ifm) rdata = ifm_cfg_q;
		if (a == OFF_RELAY_VAL) rdata = {24'h0, relay_save_q};
		if (a == OFF_WORD_VAL) rdata = {16'h0, word_save_q};
		if (hit_hist) rdata = {16'h0, hist_cnt_q};
		if (a == OFF_PENDING) rdata = {16'(ifm_pend_q), 16'(pend_q)};
		if (a == OFF_ERR_CODE) rdata = {16'h0, err_code_q};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= 5'h01;
			src_sev_q <= RST_SRC_SEV;
			ifm_cfg_q <= RST_IFM_CFG;
			int_mask_q <= '0;
			rsp_q <= '0;
		end else begin
			rsp_q.pready <= apb_req.psel & ~apb_req.penable;
			rsp_q.pslverr <= apb_req.psel & ~apb_req.penable & ~mapped;
			rsp_q.prdata <= rdata;
			if (wr & hit_ctrl) ctrl_q <= {1'b0, apb_req.pwdata[3:0] & 4'hB};
			if (wr & hit_sev) src_sev_q <= apb_req.pwdata;
			if (wr & hit_ifm) ifm_cfg_q <= apb_req.pwdata;
			if (wr & hit_mask) int_mask_q <= apb_req.pwdata[IRQ_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_stat_q <= '0;
		end else begin
			// set wins over a write-one clear in the same cycle
			int_stat_q <= (int_stat_q & ~((wr & hit_stat) ? apb_req.pwdata[IRQ_W-1:0] : '0)) | irq_evt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_q <= '0;
			ifm_pend_q <= '0;
			logged_q <= '0;
			ifm_logged_q <= '0;
			hist_cnt_q <= RST_HIST_CNT;
			err_code_q <= 16'h0000;
			state_q <= RUN_ST;
		end else begin
			state_q <= state_d;
			// cancel drops only continuable ones; a new event in the same cycle is kept
			pend_q <= (pend_q & ~(do_cancel ? cont_mask : '0)) | evt_rise;
			ifm_pend_q <= (ifm_pend_q & ~(do_cancel ? ifm_cont_mask : '0)) | ifm_rise;
			logged_q <= (logged_q & ~(do_cancel ? cont_mask : '0)) | evt_rise;
			ifm_logged_q <= (ifm_logged_q & ~(do_cancel ? ifm_cont_mask : '0)) | ifm_rise;
			if ((new_src != '0) | (new_ifm != '0)) begin
				hist_cnt_q <= hist_cnt_q + 16'h0001;
				err_code_q <= {8'(new_ifm), 8'(new_src)};
			end
		end
	end

	// ---- status image: saved at first error, restored when a cancel drops the last continuable and no stop error is pending
	// status levels come through two flops; a word caught mid-change is taken as is
	status_img_t live, save_q, img_q;
	logic restore_q;
	assign live.relay = rin_s2_q;
	assign live.word = win_s2_q;
	assign live.err_led = any_stop;
	assign live.alarm_led = any_minor;
	assign live.run_led = state_q == RUN_ST;
	// an idle cancel restores nothing, so a stale snapshot never reappears
	wire all_cleared = do_cancel & any_minor & ~any_stop & (evt_rise == '0) & (ifm_rise == '0);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			save_q <= '{relay: RST_RELAY, word: RST_WORD, err_led: 1'b0, alarm_led: 1'b0, run_led: 1'b1};
			img_q <= '{relay: RST_RELAY, word: RST_WORD, err_led: 1'b0, alarm_led: 1'b0, run_led: 1'b1};
			relay_save_q <= RST_RELAY;
			word_save_q <= RST_WORD;
			restore_q <= 1'b0;
		end else begin
			if (first_err) begin
				save_q <= '{relay: rin_s2_q, word: win_s2_q,
					err_led: 1'b0, alarm_led: 1'b0, run_led: state_q == RUN_ST};
				relay_save_q <= rin_s2_q;
				word_save_q <= win_s2_q;
			end
			// restored bits hold until the next error; live changes in between stay hidden
			if (first_err) restore_q <= 1'b0;
			else if (all_cleared) restore_q <= 1'b1;
			if (all_cleared) img_q <= save_q;
			else if (restore_q) img_q <= '{relay: save_q.relay, word: save_q.word, err_led: live.err_led,
				alarm_led: live.alarm_led, run_led: live.run_led};
			else img_q <= live;
		end
	end

	// ---- outputs, all registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_enable <= 1'b0;
			outputs_hold <= 1'b0;
			outputs_off <= 1'b1;
			irq <= 1'b0;
		end else begin
			run_enable <= state_d == RUN_ST;
			// output mode while stopped or halted: 1 holds last outputs, 0 turns them off
			outputs_hold <= state_d != RUN_ST & ctrl_q[CTRL_OUT_MODE_BIT];
			outputs_off <= state_d != RUN_ST & ~ctrl_q[CTRL_OUT_MODE_BIT];
			irq <= |(int_stat_q & int_mask_q);
		end
	end
	assign special_relay_bits = img_q.relay;
	assign special_register_words = img_q.word;
	assign err_led = img_q.err_led;
	assign alarm_led = img_q.alarm_led;
	assign run_led = img_q.run_led;
	assign apb_rsp = rsp_q;
endmodule : err_severity_mgr
`default_nettype wire

// ==== pkg/err_sev_pkg.sv ====
// package for the error severity manager: register map, field layout, reset values
`default_nettype none
package err_sev_pkg;
	localparam int unsigned NUM_SRC = 8;
	localparam int unsigned NUM_IFM = 4;
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_STATE = 12'h004;
	localparam logic [11:0] OFF_INT_STAT = 12'h008;
	localparam logic [11:0] OFF_INT_MASK = 12'h00C;
	localparam logic [11:0] OFF_SRC_SEV = 12'h010;
	localparam logic [11:0] OFF_IFM_CFG = 12'h014;
	localparam logic [11:0] OFF_RELAY_VAL = 12'h018;
	localparam logic [11:0] OFF_WORD_VAL = 12'h01C;
	localparam logic [11:0] OFF_HIST = 12'h020;
	localparam logic [11:0] OFF_PENDING = 12'h024;
	localparam logic [11:0] OFF_ERR_CODE = 12'h028;
	localparam int unsigned CTRL_RUN_BIT = 0;
	localparam int unsigned CTRL_CLR_RELAY_BIT = 1;
	localparam int unsigned CTRL_TOOL_CLR_BIT = 2;
	localparam int unsigned CTRL_OUT_MODE_BIT = 3;
	localparam int unsigned CTRL_RESTART_BIT = 4;
	localparam int unsigned IRQ_MAJOR = 0;
	localparam int unsigned IRQ_MODERATE = 1;
	localparam int unsigned IRQ_MINOR = 2;
	localparam int unsigned IRQ_CLEARED = 3;
	localparam int unsigned IRQ_LOGGED = 4;
	localparam int unsigned IRQ_W = 5;
	localparam logic [31:0] RST_SRC_SEV = 32'h0000_5555;
	localparam logic [31:0] RST_IFM_CFG = 32'h0000_0000;
	localparam logic [7:0] RST_RELAY = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [15:0] RST_HIST_CNT = 16'h0000;
	typedef enum logic [1:0] {
		SEV_NONE = 2'b00,
		SEV_MINOR = 2'b01,
		SEV_MODERATE = 2'b10,
		SEV_MAJOR = 2'b11
	} sev_t;
	typedef enum logic [1:0] {
		RUN_ST = 2'b00,
		STOP_ST = 2'b01,
		HALT_ST = 2'b10
	} op_state_t;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;
	typedef struct packed {
		logic [7:0] relay;
		logic [15:0] word;
		logic err_led;
		logic alarm_led;
		logic run_led;
	} status_img_t;
endpackage : err_sev_pkg
`default_nettype wire

// ==== rtl/err_clear_edge.sv ====
// detects the on-then-off sequence of the error-clear relay bit
`timescale 1ns/100ps
`default_nettype none
module err_clear_edge (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic relay_in,
	output logic armed,
	output logic fire
);
	import err_sev_pkg::*;
	logic seen_on_q;
	logic fire_q;
	// only the falling edge after a seen rise cancels; a bit left on does nothing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_on_q <= 1'b0;
			fire_q <= 1'b0;
		end else begin
			fire_q <= seen_on_q & ~relay_in;
			seen_on_q <= relay_in;
		end
	end
	assign armed = seen_on_q;
	assign fire = fire_q;
endmodule : err_clear_edge
`default_nettype wire

// ==== dv/err_severity_mgr_checker.sv ====
// port checker for the error severity manager
`timescale 1ns/100ps
`default_nettype none
module err_severity_mgr_checker import err_sev_pkg::*; #(
	parameter int unsigned N_SRC = NUM_SRC,
	parameter int unsigned N_IFM = NUM_IFM
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire err_sev_pkg::apb_req_t apb_req,
	input wire err_sev_pkg::apb_rsp_t apb_rsp,
	input wire logic [N_SRC-1:0] err_evt,
	input wire logic [N_IFM-1:0] ifm_err_evt,
	input wire logic run_enable,
	input wire logic outputs_hold,
	input wire logic outputs_off
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [N_SRC+N_IFM-1:0] ev_q;
	logic [5:0] rise_q;
	logic [3:0] rs_q;
	wire rise = |({ifm_err_evt, err_evt} & ~ev_q);
	wire restart_wr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == OFF_CTRL
		&& apb_req.pwdata[CTRL_RESTART_BIT];
	// reset release counts as a restart, so the window starts full
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_q <= '0;
			rise_q <= '0;
			rs_q <= 4'hF;
		end else begin
			ev_q <= {ifm_err_evt, err_evt};
			rise_q <= {rise_q[4:0], rise};
			rs_q <= {rs_q[2:0], restart_wr};
		end
	end
	sequence setup_s;
		apb_req.psel && !apb_req.penable;
	endsequence
	chk_ready_next: assert property (setup_s |=> apb_rsp.pready) else $error("no ready after setup");
	chk_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("ready too long");
	chk_ready_cause: assert property ($rose(apb_rsp.pready) |-> $past(apb_req.psel && !apb_req.penable))
		else $error("ready without setup");
	chk_err_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready) else $error("error without ready");
	chk_stop_outputs: assert property (!run_enable |-> outputs_hold != outputs_off)
		else $error("stop outputs wrong");
	chk_run_outputs: assert property (run_enable && $past(run_enable) |-> !outputs_hold && !outputs_off)
		else $error("outputs touched while running");
	chk_stop_cause: assert property ($fell(run_enable) |-> |rise_q[5:1])
		else $error("stop without error event");
	chk_run_cause: assert property ($rose(run_enable) |-> |rs_q)
		else $error("run without restart");
endmodule : err_severity_mgr_checker
bind err_severity_mgr err_severity_mgr_checker #(.N_SRC(N_SRC), .N_IFM(N_IFM)) u_chk (.pclk(pclk),
	.presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .err_evt(err_evt), .ifm_err_evt(ifm_err_evt),
	.run_enable(run_enable), .outputs_hold(outputs_hold), .outputs_off(outputs_off));
`default_nettype wire

// ==== dv/err_severity_mgr_tb.sv ====
// testbench for the error severity manager
`timescale 1ns/100ps
`default_nettype none
module err_severity_mgr_tb;
	import err_sev_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	apb_req_t req = '0;
	apb_rsp_t rsp;
	logic [11:0] evt = '0;
	logic [7:0] hw = '0;
	logic [7:0] rin = '0;
	logic [15:0] win = '0;
	logic [7:0] rout;
	logic [15:0] wout;
	logic run, hold, off, irq;
	logic eled, aled, rled;
	int fail_count = 0;
	int n_tests = 0;
	logic [31:0] d;
	logic e;
	err_severity_mgr u_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.err_evt(evt[7:0]), .ifm_err_evt(evt[11:8]), .hw_fault(hw), .special_relay_bits_in(rin),
		.special_register_words_in(win), .special_relay_bits(rout), .special_register_words(wout),
		.run_enable(run), .outputs_hold(hold), .outputs_off(off), .err_led(eled), .alarm_led(aled),
		.run_led(rled), .irq(irq));
	initial begin
		forever #25 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x) begin
			fail_count++;
			$display("unexpected t=%0t got %h exp %h", $time, g, x);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		req <= '{1'b1, 1'b0, w, a, wd};
		@(posedge pclk);
		req.penable <= 1'b1;
		do @(posedge pclk); while (rsp.pready !== 1'b1);
		d = rsp.prdata;
		e = rsp.pslverr;
		req <= '0;
		repeat (2) @(posedge pclk);
	endtask : xfer
	task automatic wr(input logic [11:0] a, input logic [31:0] wd);
		xfer(1'b1, a, wd);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		xfer(1'b0, a, 32'h0000_0000);
		chk(d, x);
	endtask : rd
	// pin held two cycles so the synchroniser sees it; pend plus stop land within 4
	task automatic ev(input logic [11:0] s);
		@(posedge pclk);
		evt <= s;
		repeat (2) @(posedge pclk);
		evt <= '0;
		repeat (6) @(posedge pclk);
	endtask : ev
	task automatic rst();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
	endtask : rst
	task automatic done(input int k);
		$display("test %0d finished", k);
	endtask : done
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		end_sim();
	end
	initial begin
		rst();
		rd(OFF_SRC_SEV, 32'h0000_5555);
		rd(OFF_IFM_CFG, 32'h0000_0000);
		xfer(1'b0, 12'h030, 32'h0000_0000);
		chk({31'h0, e}, 32'h1);
		done(1);
		rin <= 8'h5A;
		win <= 16'h1234;
		wr(OFF_INT_MASK, 32'h0000_001F);
		ev(12'h001);
		chk({31'h0, run}, 32'h1);
		chk({30'h0, aled, eled}, 32'h2);
		rd(OFF_STATE, 32'h0000_0004);
		chk({31'h0, irq}, 32'h1);
		rin <= 8'hFF;
		win <= 16'hBEEF;
		wr(OFF_INT_MASK, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0);
		wr(OFF_INT_MASK, 32'h0000_001F);
		wr(OFF_CTRL, 32'h0000_0003);
		wr(OFF_CTRL, 32'h0000_0001);
		// the restored image lands two edges after the relay bit goes off
		@(posedge pclk);
		chk({24'h0, rout}, 32'h0000_005A);
		chk({16'h0, wout}, 32'h0000_1234);
		chk({29'h0, rled, aled, eled}, 32'h4);
		rd(OFF_PENDING, 32'h0000_0000);
		chk({24'h0, rout}, 32'h0000_005A);
		wr(OFF_INT_STAT, 32'h0000_001F);
		chk({31'h0, irq}, 32'h0);
		rd(OFF_HIST, 32'h0000_0001);
		ev(12'h001);
		rd(OFF_HIST, 32'h0000_0002);
		done(2);
		ev(12'h002);
		rd(OFF_PENDING, 32'h0000_0003);
		wr(OFF_CTRL, 32'h0000_0005);
		rd(OFF_PENDING, 32'h0000_0000);
		done(3);
		wr(OFF_SRC_SEV, 32'h0000_5559);
		ev(12'h002);
		chk({31'h0, run}, 32'h0);
		chk({31'h0, off}, 32'h1);
		chk({29'h0, rled, aled, eled}, 32'h1);
		ev(12'h001);
		xfer(1'b0, OFF_STATE, 32'h0000_0000);
		chk(d & 32'h0000_000C, 32'h0000_0008);
		wr(OFF_CTRL, 32'h0000_0005);
		rd(OFF_PENDING, 32'h0000_0002);
		wr(OFF_CTRL, 32'h0000_0011);
		chk({31'h0, run}, 32'h0);
		done(4);
		rst();
		wr(OFF_CTRL, 32'h0000_0009);
		hw <= 8'h04;
		ev(12'h004);
		chk({31'h0, run}, 32'h0);
		chk({31'h0, hold}, 32'h1);
		xfer(1'b0, OFF_STATE, 32'h0000_0000);
		chk(d & 32'h0000_000C, 32'h0000_000C);
		done(5);
		rst();
		hw <= '0;
		wr(OFF_IFM_CFG, 32'h0000_0008);
		ev(12'h100);
		chk({31'h0, run}, 32'h1);
		ev(12'h200);
		chk({31'h0, run}, 32'h0);
		done(6);
		end_sim();
	end
endmodule : err_severity_mgr_tb
`default_nettype wire
